// ===== logic/fwc_pkg.sv
// Purpose: Constants and types of the flash write control
// Assumes: 20-bit byte addresses on both ports
// Notes: Functional notes below
package fwc_pkg;
   localparam int ADDR_W = 20;
   localparam logic [19:0] PRIM_LAST = 20'h8ffff;
   localparam logic [19:0] EXT_BASE = 20'h90000;
   localparam logic [19:0] EXT_LAST = 20'hdffff;
   localparam logic [19:0] REG_BASE = 20'he0000;
   localparam logic [19:0] REG_LAST = 20'heffff;
   localparam logic [19:0] TEST_BASE = 20'he8000;
   localparam logic [19:0] BANK1_BASE = 20'h80000;
   localparam logic [19:0] BANK3_BASE = 20'hc0000;
   localparam logic [19:0] OFS_CTRL0_LOW = 20'he0000;
   localparam logic [19:0] OFS_CMD = 20'he0010;
   localparam logic [19:0] OFS_BANK_STAT = 20'he0014;
   localparam logic [19:0] OFS_IRQ_STAT = 20'he0018;
   localparam logic [19:0] OFS_IRQ_CLR = 20'he001c;
   localparam logic [19:0] OFS_IRQ_EN = 20'he0020;
   localparam int CTRL0_BANK2_BUSY_FLAG_BIT = 1;
   localparam int CTRL0_BANK3_BUSY_FLAG_BIT = 2;
   localparam int CTRL0_LOCK_BIT = 4;
   localparam logic [15:0] CTRL0_RESET = 16'h0000;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_OP_LSB = 1;
   localparam int CMD_BANK_LSB = 4;
   localparam int CMD_SUSP_BIT = 6;
   localparam int CMD_RESUME_BIT = 7;
   localparam int STAT_SUSP_BIT = 4;
   localparam int STAT_BOOT_BIT = 5;
   localparam int IRQ_W = 4;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ABORT = 1;
   localparam int IRQ_REFUSED = 2;
   localparam int IRQ_TRAP = 3;
   localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;
   localparam logic [15:0] TRAP_NUM = 16'h009b;
   localparam logic [31:0] INVALID_DATA = 32'hffff_ffff;
   localparam logic [1:0] PROT_BANK = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int OP_CYCLES_DEF = 1000;
   typedef enum logic [1:0] {
      OP_PROGRAM = 2'b00,
      OP_ERASE = 2'b01,
      OP_SET_PROT = 2'b10,
      OP_SPARE = 2'b11
   } fwc_op_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_SUSP = 2'b10
   } fwc_state_type;
endpackage

// ===== logic/fwc_seq_if.sv
// Purpose: Front end to program/erase controller link
// Assumes: All strobes but abort are one-cycle pulses on clock_in
// Notes: ctl side issues commands, seq side reports state
`timescale 1ns/1ns
interface fwc_seq_if;
   import fwc_pkg::*;
   logic start;
   fwc_op_type op;
   logic [1:0] bank;
   logic suspend;
   logic resume;
   logic abort;
   logic [3:0] busy;
   logic lock;
   logic done;
   logic aborted;
   logic suspended;
   logic pump_en;
   modport ctl (output start, op, bank, suspend, resume, abort,
      input busy, lock, done, aborted, suspended, pump_en);
   modport seq (input start, op, bank, suspend, resume, abort,
      output busy, lock, done, aborted, suspended, pump_en);
endinterface

// ===== logic/fwc_seq.sv
// Purpose: Program/erase controller shared by all four banks
// Assumes: abort is a synchronised level
// Notes: One operation at a time; starts while busy are dropped
`timescale 1ns/1ns
module fwc_seq #(
   parameter int OP_CYCLES = fwc_pkg::OP_CYCLES_DEF
) (
   input wire logic clock_in,
   input wire logic rst_in,
   fwc_seq_if.seq sif
);
   import fwc_pkg::*;
   localparam int CNT_W = $clog2(OP_CYCLES + 1);
   fwc_state_type state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [1:0] bank_ff;
   logic [3:0] busy_ff;
   logic done_ff;
   logic aborted_ff;
   logic [1:0] tgt;
   logic last;

   // Protection words live in bank 2
   assign tgt = (sif.op == OP_SET_PROT) ? PROT_BANK : sif.bank;
   assign last = (cnt_ff == CNT_W'(1));

   always_ff @(posedge clock_in) begin
      if (rst_in || sif.abort) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: if (sif.start) state_ff <= ST_RUN;
            ST_RUN: begin
               if (sif.suspend) begin
                  state_ff <= ST_SUSP;
               end else if (last) begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_SUSP: if (sif.resume) state_ff <= ST_RUN;
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cnt_ff <= '0;
         bank_ff <= 2'h0;
      end else if (state_ff == ST_IDLE && sif.start) begin
         cnt_ff <= CNT_W'(OP_CYCLES);
         bank_ff <= tgt;
      end else if (state_ff == ST_RUN && !sif.suspend && !last) begin
         cnt_ff <= cnt_ff - CNT_W'(1);
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in || sif.abort) begin
         busy_ff <= 4'h0;
      end else if (state_ff == ST_IDLE && sif.start) begin
         busy_ff <= 4'h1 << tgt;
      end else if (state_ff == ST_RUN && (sif.suspend || last)) begin
         busy_ff <= 4'h0;
      end else if (state_ff == ST_SUSP && sif.resume) begin
         busy_ff <= 4'h1 << bank_ff;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         done_ff <= 1'b0;
         aborted_ff <= 1'b0;
      end else begin
         done_ff <= !sif.abort && state_ff == ST_RUN && !sif.suspend && last;
         aborted_ff <= sif.abort && state_ff != ST_IDLE;
      end
   end

   assign sif.busy = busy_ff;
   assign sif.lock = (state_ff == ST_RUN);
   assign sif.suspended = (state_ff == ST_SUSP);
   assign sif.pump_en = (state_ff == ST_RUN);
   assign sif.done = done_ff;
   assign sif.aborted = aborted_ff;
endmodule

// ===== logic/fwc_top.sv
// Purpose: Flash write control front end: decode, bank guard, registers
// Assumes: Array answers in the cycle of its read enable
// Notes: Registers over AXI4-Lite; core array port is separate
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module fwc_top #(
   parameter int OP_CYCLES = fwc_pkg::OP_CYCLES_DEF
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [fwc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [fwc_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic acc_valid_in,
   input wire logic acc_write_in,
   input wire logic [fwc_pkg::ADDR_W-1:0] acc_addr_in,
   output logic acc_ready_out,
   output logic acc_done_out,
   output logic [31:0] acc_rdata_out,
   output logic acc_wide_out,
   output logic acc_trap_out,
   output logic [15:0] acc_trap_num_out,
   output logic acc_refused_out,
   output logic arr_rd_en_out,
   output logic arr_wr_en_out,
   output logic [fwc_pkg::ADDR_W-1:0] arr_addr_out,
   input wire logic [31:0] arr_rdata_in,
   input wire logic bootstrap_in,
   input wire logic supply_low_in,
   output logic hv_pump_en_out,
   output logic irq_out
);
   import fwc_pkg::*;

   fwc_seq_if sif();

   fwc_seq #(.OP_CYCLES(OP_CYCLES)) u_seq (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .sif(sif)
   );

   function automatic logic [1:0] bank_of(input logic [ADDR_W-1:0] a);
      if (a < BANK1_BASE) begin
         bank_of = 2'h0;
      end else if (a < EXT_BASE) begin
         bank_of = 2'h1;
      end else if (a < BANK3_BASE) begin
         bank_of = 2'h2;
      end else begin
         bank_of = 2'h3;
      end
   endfunction

   // Word offset that holds a register
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] w;
      w = {a[ADDR_W-1:2], 2'b00};
      mapped = (w == OFS_CTRL0_LOW) || (w == OFS_CMD) ||
         (w == OFS_BANK_STAT) || (w == OFS_IRQ_STAT) ||
         (w == OFS_IRQ_CLR) || (w == OFS_IRQ_EN);
   endfunction

   // Supply pin: three stages, taken when two and three agree
   logic sup1_ff;
   logic sup2_ff;
   logic sup3_ff;
   logic supply_low_ff;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sup1_ff <= 1'b0;
         sup2_ff <= 1'b0;
         sup3_ff <= 1'b0;
         supply_low_ff <= 1'b0;
      end else begin
         sup1_ff <= supply_low_in;
         sup2_ff <= sup1_ff;
         sup3_ff <= sup2_ff;
         if (sup2_ff == sup3_ff) begin
            supply_low_ff <= sup3_ff;
         end
      end
   end
   assign sif.abort = supply_low_ff;

   // Strap is caught while reset is held
   logic boot_ff;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         boot_ff <= bootstrap_in;
      end
   end

   // AXI4-Lite write side: address and data are taken together
   logic wr_go;
   logic [ADDR_W-1:0] wr_word;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   assign wr_go = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_ff;
   assign wr_word = {s_axi_awaddr_in[ADDR_W-1:2], 2'b00};
   assign s_axi_awready_out = wr_go;
   assign s_axi_wready_out = wr_go;
   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= mapped(s_axi_awaddr_in) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         bvalid_ff <= 1'b0;
      end
   end

   logic lane0;
   logic cmd_wr;
   assign lane0 = wr_go && s_axi_wstrb_in[0];
   assign cmd_wr = lane0 && wr_word == OFS_CMD;

   // Start, suspend and resume are one-cycle pulses
   logic start_ff;
   logic susp_ff;
   logic resume_ff;
   fwc_op_type op_ff;
   logic [1:0] cmd_bank_ff;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         start_ff <= 1'b0;
         susp_ff <= 1'b0;
         resume_ff <= 1'b0;
      end else begin
         start_ff <= cmd_wr && s_axi_wdata_in[CMD_START_BIT];
         susp_ff <= cmd_wr && s_axi_wdata_in[CMD_SUSP_BIT];
         resume_ff <= cmd_wr && s_axi_wdata_in[CMD_RESUME_BIT];
      end
   end

   // Op and bank frozen while running or suspended
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         op_ff <= OP_PROGRAM;
         cmd_bank_ff <= 2'h0;
      end else if (cmd_wr && !sif.lock && !sif.suspended) begin
         op_ff <= fwc_op_type'(s_axi_wdata_in[CMD_OP_LSB +: 2]);
         cmd_bank_ff <= s_axi_wdata_in[CMD_BANK_LSB +: 2];
      end
   end
   assign sif.start = start_ff;
   assign sif.suspend = susp_ff;
   assign sif.resume = resume_ff;
   assign sif.op = op_ff;
   assign sif.bank = cmd_bank_ff;
   assign hv_pump_en_out = sif.pump_en;

   // Interrupt enable
   logic [IRQ_W-1:0] irq_en_ff;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         irq_en_ff <= IRQ_EN_RESET;
      end else if (lane0 && wr_word == OFS_IRQ_EN) begin
         irq_en_ff <= s_axi_wdata_in[IRQ_W-1:0];
      end
   end

   // Core array port
   logic [1:0] acc_bank;
   logic in_array;
   logic in_test;
   logic bank_busy;
   logic acc_take;
   logic pend_ff;
   logic bad_ff;
   logic trap_ff;
   logic wide_ff;
   logic rd_ff;
   logic done_ff;
   logic refused_ff;
   logic trap_out_ff;
   logic wide_out_ff;
   logic [31:0] rdata_ff;
   logic rd_ok;
   logic wr_ok;
   logic [ADDR_W-1:0] arr_addr_ff;
   logic arr_rd_ff;
   logic arr_wr_ff;

   assign acc_bank = bank_of(acc_addr_in);
   assign in_array = (acc_addr_in <= EXT_LAST);
   assign in_test = (acc_addr_in >= TEST_BASE) &&
      (acc_addr_in <= REG_LAST);
   // Only the addressed bank is guarded
   assign bank_busy = in_array && sif.busy[acc_bank];
   assign acc_ready_out = !pend_ff;
   assign acc_take = acc_valid_in && !pend_ff;
   assign rd_ok = (in_array && !bank_busy) || (in_test && boot_ff);
   // Test block and busy banks drop writes
   assign wr_ok = in_array && !bank_busy;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pend_ff <= 1'b0;
         arr_rd_ff <= 1'b0;
         arr_wr_ff <= 1'b0;
         arr_addr_ff <= '0;
         bad_ff <= 1'b0;
         trap_ff <= 1'b0;
         wide_ff <= 1'b0;
         rd_ff <= 1'b0;
      end else begin
         pend_ff <= acc_take;
         arr_rd_ff <= acc_take && !acc_write_in && rd_ok;
         arr_wr_ff <= acc_take && acc_write_in && wr_ok;
         if (acc_take) begin
            arr_addr_ff <= acc_addr_in;
            bad_ff <= acc_write_in ? !wr_ok : !rd_ok;
            trap_ff <= !acc_write_in && bank_busy;
            wide_ff <= (acc_addr_in <= PRIM_LAST);
            rd_ff <= !acc_write_in;
         end
      end
   end
   assign arr_rd_en_out = arr_rd_ff;
   assign arr_wr_en_out = arr_wr_ff;
   assign arr_addr_out = arr_addr_ff;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         done_ff <= 1'b0;
         refused_ff <= 1'b0;
         trap_out_ff <= 1'b0;
         wide_out_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         done_ff <= pend_ff;
         refused_ff <= pend_ff && bad_ff;
         trap_out_ff <= pend_ff && trap_ff;
         if (pend_ff) begin
            wide_out_ff <= wide_ff;
            if (bad_ff || !rd_ff) begin
               rdata_ff <= INVALID_DATA;
            end else if (wide_ff) begin
               rdata_ff <= arr_rdata_in;
            end else begin
               rdata_ff <= {16'h0000, arr_rdata_in[15:0]};
            end
         end
      end
   end
   assign acc_done_out = done_ff;
   assign acc_refused_out = refused_ff;
   assign acc_trap_out = trap_out_ff;
   assign acc_trap_num_out = trap_out_ff ? TRAP_NUM : 16'h0000;
   assign acc_wide_out = wide_out_ff;
   assign acc_rdata_out = rdata_ff;

   // Sticky events; a new event beats a same-cycle clear
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic [IRQ_W-1:0] irq_stat_ff;
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_DONE] = sif.done;
      irq_set[IRQ_ABORT] = sif.aborted;
      irq_set[IRQ_REFUSED] = refused_ff && !trap_out_ff;
      irq_set[IRQ_TRAP] = trap_out_ff;
   end
   assign irq_clr = (lane0 && wr_word == OFS_IRQ_CLR) ?
      s_axi_wdata_in[IRQ_W-1:0] : '0;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      end
   end
   assign irq_out = |(irq_stat_ff & irq_en_ff);

   // Read-back views; reserved bits read zero and ignore writes
   logic [15:0] ctrl0_view;
   logic [15:0] stat_view;
   logic [15:0] cmd_view;
   always_comb begin
      ctrl0_view = CTRL0_RESET;
      ctrl0_view[CTRL0_BANK2_BUSY_FLAG_BIT] = sif.busy[2];
      ctrl0_view[CTRL0_BANK3_BUSY_FLAG_BIT] = sif.busy[3];
      ctrl0_view[CTRL0_LOCK_BIT] = sif.lock;
      stat_view = 16'h0000;
      stat_view[3:0] = sif.busy;
      stat_view[STAT_SUSP_BIT] = sif.suspended;
      stat_view[STAT_BOOT_BIT] = boot_ff;
      cmd_view = 16'h0000;
      cmd_view[CMD_OP_LSB +: 2] = op_ff;
      cmd_view[CMD_BANK_LSB +: 2] = cmd_bank_ff;
   end

   // AXI4-Lite read side
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_reg_ff;
   logic [ADDR_W-1:0] rd_word;
   logic [31:0] rd_mux;
   assign rd_word = {s_axi_araddr_in[ADDR_W-1:2], 2'b00};
   assign s_axi_arready_out = !rvalid_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rresp_out = rresp_ff;
   assign s_axi_rdata_out = rdata_reg_ff;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (rd_word)
         OFS_CTRL0_LOW: rd_mux = {16'h0000, ctrl0_view};
         OFS_CMD: rd_mux = {16'h0000, cmd_view};
         OFS_BANK_STAT: rd_mux = {16'h0000, stat_view};
         OFS_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_ff};
         OFS_IRQ_EN: rd_mux = {28'h0000000, irq_en_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_reg_ff <= 32'h0000_0000;
      end else if (s_axi_arvalid_in && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
         rdata_reg_ff <= rd_mux;
      end else if (s_axi_rready_in) begin
         rvalid_ff <= 1'b0;
      end
   end
endmodule

// ===== verif/fwc_array_model.sv
// Purpose: Flash array stand-in on the core port
// Assumes: Data stands only while the read enable is high
// Notes: Otherwise a rolling pattern shows, so stale reads fail
`timescale 1ns/1ns
module fwc_array_model (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic rd_en_in,
   input wire logic [19:0] addr_in,
   output logic [31:0] rdata_out
);
   logic [31:0] junk_ff;
   always_ff @(posedge clock_in) begin
      junk_ff <= rst_in ? 32'h5a3c_0f96 : {junk_ff[30:0], ~junk_ff[31]};
   end
   assign rdata_out = rd_en_in ? {12'ha5c, addr_in} : junk_ff;
endmodule

// ===== verif/fwc_top_chk.sv
// Purpose: Port-level checks of the front end
// Assumes: One clock; rst_in synchronous, active high
// Notes: Busy is not on the pins; guards show in results
`timescale 1ns/1ns
module fwc_top_chk (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic acc_valid_in,
   input wire logic acc_write_in,
   input wire logic [fwc_pkg::ADDR_W-1:0] acc_addr_in,
   input wire logic acc_ready_out,
   input wire logic acc_done_out,
   input wire logic [31:0] acc_rdata_out,
   input wire logic acc_wide_out,
   input wire logic acc_trap_out,
   input wire logic [15:0] acc_trap_num_out,
   input wire logic acc_refused_out,
   input wire logic arr_rd_en_out,
   input wire logic arr_wr_en_out,
   input wire logic [fwc_pkg::ADDR_W-1:0] arr_addr_out,
   input wire logic bootstrap_in,
   input wire logic supply_low_in,
   input wire logic hv_pump_en_out
);
   import fwc_pkg::*;
   logic take, rd, en, in_test;
   assign take = acc_valid_in && acc_ready_out;
   assign rd = take && !acc_write_in;
   assign en = arr_rd_en_out || arr_wr_en_out;
   assign in_test = acc_addr_in >= TEST_BASE && acc_addr_in <= REG_LAST;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   property p_trap;
      acc_trap_out |-> acc_trap_num_out == TRAP_NUM
         && acc_rdata_out == INVALID_DATA && acc_refused_out;
   endproperty
   a_trap: assert property (p_trap) else $error("trap result wrong");
   property p_done;
      take |-> ##2 acc_done_out;
   endproperty
   a_done: assert property (p_done) else $error("no done");
   // Served accesses reach the array, guarded ones never do
   property p_guard;
      take |=> (en ##1 !acc_refused_out) or (!en ##1 acc_refused_out);
   endproperty
   a_guard: assert property (p_guard) else $error("guard wrong");
   property p_wide;
      rd && acc_addr_in < BANK1_BASE |-> ##2 (acc_refused_out || acc_wide_out);
   endproperty
   a_wide: assert property (p_wide) else $error("not 32-bit path");
   property p_narrow;
      rd && acc_addr_in >= EXT_BASE && acc_addr_in <= EXT_LAST |-> ##2
         (acc_refused_out || !acc_wide_out && acc_rdata_out[31:16] == 16'h0);
   endproperty
   a_narrow: assert property (p_narrow) else $error("not 16-bit");
   property p_test_wr;
      take && acc_write_in && in_test |-> ##2 acc_refused_out;
   endproperty
   a_test_wr: assert property (p_test_wr) else $error("test write");
   property p_test_rd;
      rd && in_test && !bootstrap_in |-> ##2 acc_refused_out;
   endproperty
   a_test_rd: assert property (p_test_rd) else $error("test read");
   property p_addr;
      en |-> arr_addr_out == $past(acc_addr_in) && $past(take);
   endproperty
   a_addr: assert property (p_addr) else $error("array address");
   property p_regwin;
      take && acc_addr_in >= REG_BASE && acc_addr_in < TEST_BASE |-> ##2
         acc_refused_out;
   endproperty
   a_regwin: assert property (p_regwin) else $error("reg window");
   property p_supply;
      supply_low_in [*6] |-> !hv_pump_en_out;
   endproperty
   a_supply: assert property (p_supply) else $error("pump on");
   c_trap: cover property (acc_trap_out);
   c_refused: cover property (acc_refused_out && !acc_trap_out);
   c_abort: cover property (hv_pump_en_out ##1 supply_low_in [*5]);
endmodule
bind fwc_top fwc_top_chk i_chk (.clock_in,
   .rst_in, .acc_valid_in, .acc_write_in, .acc_addr_in, .acc_ready_out,
   .acc_done_out, .acc_rdata_out, .acc_wide_out, .acc_trap_out,
   .acc_trap_num_out, .acc_refused_out, .arr_rd_en_out, .arr_wr_en_out,
   .arr_addr_out, .bootstrap_in, .supply_low_in, .hv_pump_en_out);

// ===== verif/dual_module_flash_write_control_test.sv
// Purpose: Register and core-port tests
// Assumes: Short OP_CYCLES
// Notes: Only suspend is written while locked
`timescale 1ns/1ns
module dual_module_flash_write_control_test;
   import fwc_pkg::*;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic [19:0] s_axi_awaddr_in = 20'h0, s_axi_araddr_in = 20'h0;
   logic [19:0] acc_addr_in = 20'h0, arr_addr_out;
   logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, acc_rdata_out;
   logic [31:0] arr_rdata_in;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
   logic s_axi_arvalid_in = 1'b0, acc_valid_in = 1'b0, acc_write_in = 1'b0;
   logic s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1;
   logic bootstrap_in = 1'b0, supply_low_in = 1'b0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, acc_ready_out, acc_done_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   logic acc_wide_out, acc_trap_out, acc_refused_out, arr_rd_en_out;
   logic arr_wr_en_out, hv_pump_en_out, irq_out;
   logic [15:0] acc_trap_num_out;
   int err_total = 0;
   int cmp_count = 0;
   always #20 clock_in = ~clock_in;
   fwc_top #(.OP_CYCLES(40)) i_dut (.clock_in, .rst_in, .s_axi_awaddr_in,
      .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
      .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
      .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
      .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
      .s_axi_rready_in, .acc_valid_in, .acc_write_in, .acc_addr_in,
      .acc_ready_out, .acc_done_out, .acc_rdata_out, .acc_wide_out,
      .acc_trap_out, .acc_trap_num_out, .acc_refused_out, .arr_rd_en_out,
      .arr_wr_en_out, .arr_addr_out, .arr_rdata_in, .bootstrap_in,
      .supply_low_in, .hv_pump_en_out, .irq_out);
   fwc_array_model i_arr (.clock_in, .rst_in, .rd_en_in(arr_rd_en_out),
      .addr_in(arr_addr_out), .rdata_out(arr_rdata_in));
   task report_and_stop;
      $display("Checks %0d, errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", what, e, g);
         err_total++;
      end
   endtask
   wire [5:0] hs = {acc_done_out, acc_ready_out, s_axi_rvalid_out,
      s_axi_arready_out, s_axi_bvalid_out, s_axi_awready_out};
   task wait_on(input int w);
      int n;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (hs[w] !== 1'b1 && n < 60);
      if (hs[w] !== 1'b1) begin
         $display("Error handshake %0d expected 1 seen timeout", w);
         err_total++;
         report_and_stop();
      end
   endtask
   task axi_wr(input logic [19:0] a, input logic [31:0] d);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      wait_on(0);
      s_axi_awvalid_in <= 1'b0;
      s_axi_wvalid_in <= 1'b0;
      wait_on(1);
      chk($sformatf("bresp %h", a), {30'h0, (a == 20'he0040) ? RESP_SLVERR
         : RESP_OKAY}, {30'h0, s_axi_bresp_out});
   endtask
   task axi_rd(input logic [19:0] a, output logic [31:0] d,
      output logic [1:0] r);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      wait_on(2);
      s_axi_arvalid_in <= 1'b0;
      wait_on(3);
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
   endtask
   task reg_chk(input logic [19:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk($sformatf("reg %h", a), e, d);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask
   // Busy lands one edge after the write response shows; all three are spare
   task cmd(input logic [31:0] c);
      axi_wr(OFS_CMD, c);
      repeat (3) @(posedge clock_in);
   endtask
   task wait_idle;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      do begin
         axi_rd(OFS_CTRL0_LOW, d, r);
         n++;
      end while (d !== 32'h0 && n < 40);
      chk("idle", 32'h0, d);
      if (d !== 32'h0) report_and_stop();
   endtask
   task acc(input logic w, input logic [19:0] a, input logic ef,
      input logic et, input logic [31:0] ed);
      acc_valid_in <= 1'b1;
      acc_write_in <= w;
      acc_addr_in <= a;
      wait_on(4);
      acc_valid_in <= 1'b0;
      wait_on(5);
      chk($sformatf("refused %h", a), {31'h0, ef}, {31'h0, acc_refused_out});
      chk("trap", {31'h0, et}, {31'h0, acc_trap_out});
      if (!w && (et || !ef)) begin
         chk($sformatf("rdata %h", a), ed, acc_rdata_out);
      end
   endtask
   function automatic logic [31:0] pat(input logic [19:0] a);
      return {12'ha5c, a};
   endfunction
   function automatic logic [31:0] ext(input logic [19:0] a);
      return {16'h0, a[15:0]};
   endfunction
   task tend(input string t);
      $display("Test %s done, errors %0d", t, err_total);
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      reg_chk(OFS_CTRL0_LOW, 32'h0);
      reg_chk(OFS_IRQ_EN, 32'h0);
      reg_chk(OFS_BANK_STAT, 32'h0);
      axi_wr(OFS_CTRL0_LOW, 32'hffff);
      reg_chk(OFS_CTRL0_LOW, 32'h0);
      axi_wr(20'he0040, 32'h1);
      axi_rd(20'he0040, d, r);
      chk("unmapped rdata", 32'h0, d);
      chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      tend("registers");
      acc(1'b0, 20'h00100, 1'b0, 1'b0, pat(20'h00100));
      acc(1'b0, 20'h8fff0, 1'b0, 1'b0, pat(20'h8fff0));
      acc(1'b0, EXT_BASE, 1'b0, 1'b0, ext(EXT_BASE));
      acc(1'b0, 20'hdfffc, 1'b0, 1'b0, ext(20'hdfffc));
      acc(1'b1, 20'h00200, 1'b0, 1'b0, 32'h0);
      acc(1'b0, REG_BASE, 1'b1, 1'b0, 32'h0);
      acc(1'b0, TEST_BASE, 1'b1, 1'b0, 32'h0);
      acc(1'b1, TEST_BASE, 1'b1, 1'b0, 32'h0);
      tend("array map");
      axi_wr(OFS_IRQ_CLR, 32'hf);
      axi_wr(OFS_IRQ_EN, 32'h1);
      cmd(32'h31);
      reg_chk(OFS_CTRL0_LOW, 32'h14);
      reg_chk(OFS_BANK_STAT, 32'h8);
      acc(1'b0, BANK3_BASE, 1'b1, 1'b1, INVALID_DATA);
      acc(1'b1, BANK3_BASE + 20'h4, 1'b1, 1'b0, 32'h0);
      acc(1'b0, 20'h90100, 1'b0, 1'b0, ext(20'h90100));
      acc(1'b0, 20'h00100, 1'b0, 1'b0, pat(20'h00100));
      chk("irq masked", 32'h0, {31'h0, irq_out});
      wait_idle();
      reg_chk(OFS_IRQ_STAT, 32'hd);
      chk("irq done", 32'h1, {31'h0, irq_out});
      acc(1'b0, BANK3_BASE, 1'b0, 1'b0, ext(BANK3_BASE));
      axi_wr(OFS_IRQ_EN, 32'h0);
      chk("irq disabled", 32'h0, {31'h0, irq_out});
      axi_wr(OFS_IRQ_EN, 32'h1);
      axi_wr(OFS_IRQ_CLR, 32'hf);
      reg_chk(OFS_IRQ_STAT, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
      tend("program bank 3");
      cmd(32'h05);
      reg_chk(OFS_CTRL0_LOW, 32'h12);
      chk("pump", 32'h1, {31'h0, hv_pump_en_out});
      cmd(32'h40);
      reg_chk(OFS_CTRL0_LOW, 32'h0);
      reg_chk(OFS_BANK_STAT, 32'h10);
      acc(1'b0, 20'h90100, 1'b0, 1'b0, ext(20'h90100));
      cmd(32'h31);
      reg_chk(OFS_BANK_STAT, 32'h10);
      cmd(32'h80);
      reg_chk(OFS_CTRL0_LOW, 32'h12);
      supply_low_in <= 1'b1;
      repeat (6) @(posedge clock_in);
      chk("pump abort", 32'h0, {31'h0, hv_pump_en_out});
      reg_chk(OFS_CTRL0_LOW, 32'h0);
      reg_chk(OFS_IRQ_STAT, 32'h2);
      supply_low_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      cmd(32'h05);
      wait_idle();
      reg_chk(OFS_IRQ_STAT, 32'h3);
      tend("protect and abort");
      rst_in <= 1'b1;
      bootstrap_in <= 1'b1;
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      reg_chk(OFS_BANK_STAT, 32'h20);
      acc(1'b0, TEST_BASE, 1'b0, 1'b0, ext(TEST_BASE));
      acc(1'b1, TEST_BASE, 1'b1, 1'b0, 32'h0);
      tend("bootstrap");
      report_and_stop();
   end
endmodule
